// [rtl/gpc_pkg.sv]
// Constants shared by the configurable I/O port block: register offsets, field positions, resets, masks.
// Assumes a byte-wide microcontroller bus with a window select, an offset, and read and write strobes.
// Function
// RULE1 - Mode bit 0 gives software I/O, 1 gives latched-address output, Ports A and B.
// RULE2 - Mode register exists only for Ports A and B; all pins start in software I/O.
// RULE3 - Direction bit 1 makes the pin an output, 0 makes it an input.
// RULE4 - After reset every pin is an input until software changes its direction bit.
// RULE5 - Ports A, B, C drive when direction bit or array enable term is 1.
// RULE6 - With no active array enable term the direction bit alone sets direction.
// RULE7 - Port D has three pins, no enable term, only three direction bits active.
// RULE8 - Drive bit 1 selects open drain on A/B bits 7..4 and all of Port C.
// RULE9 - Drive bit 1 selects fast slew on A/B bits 3..0 and D bits 2..0.
// RULE10 - Input-read register returns the live pin values.
// RULE11 - Output latch stores written bytes and drives pins whenever enabled as outputs; the code drives it only on bits whose mode bit is 0.
// RULE12 - Reading the output latch returns the last written value, whatever the pins show.
// RULE13 - Output-cell read returns cell outputs; a write loads unmasked cell flip-flops.
// RULE14 - Mask bit 1 blocks bus loads of its output cell; mask resets to zero.
// RULE15 - Input cells capture pin inputs, feed the array, and are readable by software.
// RULE16 - Enable status reads 1 for a driving pin and 0 for a tri-stated input.
// RULE17 - Input and latch registers on all ports; cell, mask, status on A, B, C.
// RULE18 - All registers are reached by plain bus reads and writes at fixed window offsets.
// RULE19 - Mode, direction and drive registers reset to zero.
// RULE20 - Writes to read-only locations are ignored and disturb nothing.
package gpc_pkg;
    localparam int unsigned GPC_DATA_W      = 8;
    localparam int unsigned GPC_PORT_D_W    = 3;
    // Offset layout: high nibble selects the port, low nibble the register.
    localparam int unsigned GPC_PORT_LSB    = 4;
    localparam int unsigned GPC_REG_LSB     = 0;
    localparam logic [3:0]  GPC_PORT_A      = 4'h0;
    localparam logic [3:0]  GPC_PORT_B      = 4'h1;
    localparam logic [3:0]  GPC_PORT_C      = 4'h2;
    localparam logic [3:0]  GPC_PORT_D      = 4'h3;
    localparam logic [3:0]  GPC_REG_INPUT   = 4'h0;
    localparam logic [3:0]  GPC_REG_LATCH   = 4'h1;
    localparam logic [3:0]  GPC_REG_MODE    = 4'h2;
    localparam logic [3:0]  GPC_REG_DIR     = 4'h3;
    localparam logic [3:0]  GPC_REG_DRIVE   = 4'h4;
    localparam logic [3:0]  GPC_REG_OE_STAT = 4'h5;
    localparam logic [3:0]  GPC_REG_CELL    = 4'h6;
    localparam logic [3:0]  GPC_REG_MASK    = 4'h7;
    localparam logic [3:0]  GPC_REG_CELL_IN = 4'h8;
    // Reset values.
    localparam logic [7:0]  GPC_MODE_RST    = 8'h00;
    localparam logic [7:0]  GPC_DIR_RST     = 8'h00;
    localparam logic [7:0]  GPC_DRIVE_RST   = 8'h00;
    localparam logic [7:0]  GPC_LATCH_RST   = 8'h00;
    localparam logic [7:0]  GPC_MASK_RST    = 8'h00;
    localparam logic [7:0]  GPC_CELL_RST    = 8'h00;
    localparam logic [7:0]  GPC_RDATA_RST   = 8'h00;
    localparam logic [7:0]  GPC_UNMAPPED_RD = 8'h00;
    // Which drive bits mean open drain and which mean fast slew.
    localparam logic [7:0]  GPC_OD_MASK_AB   = 8'hF0;
    localparam logic [7:0]  GPC_SLEW_MASK_AB = 8'h0F;
    localparam logic [7:0]  GPC_OD_MASK_C    = 8'hFF;
    localparam logic [7:0]  GPC_SLEW_MASK_C  = 8'h00;
    localparam logic [7:0]  GPC_OD_MASK_D    = 8'h00;
    localparam logic [7:0]  GPC_SLEW_MASK_D  = 8'h07;
endpackage : gpc_pkg

// [rtl/gpc_ifs.sv]
// Carriers between the top and its port and cell modules.
// Assumes the top drives the write strobes and data and the leaves drive the readback.
`timescale 1ns/1ps
interface gpc_port_if #(parameter int unsigned W = 8);
    logic [7:0]   wdata;
    logic         wr_mode;
    logic         wr_dir;
    logic         wr_drive;
    logic         wr_latch;
    logic [W-1:0] mode_q;
    logic [W-1:0] dir_q;
    logic [W-1:0] drive_q;
    logic [W-1:0] latch_q;
    logic [W-1:0] oe_stat;
    logic [W-1:0] pin_live;
    modport ctrl (output wdata, wr_mode, wr_dir, wr_drive, wr_latch,
                  input mode_q, dir_q, drive_q, latch_q, oe_stat, pin_live);
    modport port (input wdata, wr_mode, wr_dir, wr_drive, wr_latch,
                  output mode_q, dir_q, drive_q, latch_q, oe_stat, pin_live);
endinterface : gpc_port_if

interface gpc_cell_if;
    logic [7:0] wdata;
    logic       wr_cell;
    logic       wr_mask;
    logic [7:0] cell_q;
    logic [7:0] mask_q;
    logic [7:0] icell_q;
    modport ctrl  (output wdata, wr_cell, wr_mask, input cell_q, mask_q, icell_q);
    modport cells (input wdata, wr_cell, wr_mask, output cell_q, mask_q, icell_q);
endinterface : gpc_cell_if

// [rtl/gpc_port.sv]
// One I/O port: mode, direction, drive and output latch registers, and the pin driver logic.
// Assumes pins are synchronous inputs and the top decodes bus writes into single strobes.
`timescale 1ns/1ps
module gpc_port
    import gpc_pkg::*;
#(
    parameter int unsigned W         = 8,
    parameter bit          HAS_MODE  = 1'b1,
    parameter logic [7:0]  OD_MASK   = GPC_OD_MASK_AB,
    parameter logic [7:0]  SLEW_MASK = GPC_SLEW_MASK_AB
) (
    // Clock and reset.
    input  wire logic         clk_sys,
    input  wire logic         reset_n,
    // Register carrier.
    gpc_port_if.port          regs,
    // Pins and array terms.
    input  wire logic [W-1:0] pin_in,
    input  wire logic [W-1:0] oe_term,
    input  wire logic [W-1:0] addr_bits,
    output logic      [W-1:0] pin_out,
    output logic      [W-1:0] pin_oe_n,
    output logic      [W-1:0] slew_fast
);
    logic [W-1:0] mode_q;
    logic [W-1:0] dir_q;
    logic [W-1:0] drive_q;
    logic [W-1:0] latch_q;
    logic [W-1:0] drive_en;
    logic [W-1:0] value;
    logic [W-1:0] open_drain;

    // Mode register; ports without one hold zero, so they stay in software I/O.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            mode_q <= GPC_MODE_RST[W-1:0]; // RULE2 RULE19
        end else if (regs.wr_mode && HAS_MODE) begin
            mode_q <= regs.wdata[W-1:0]; // RULE2
        end
    end

    // Direction register; only W bits exist, so Port D keeps three.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            dir_q <= GPC_DIR_RST[W-1:0]; // RULE4 RULE19
        end else if (regs.wr_dir) begin
            dir_q <= regs.wdata[W-1:0]; // RULE7
        end
    end

    // Drive select; bits with no function are masked so they read back as zero.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            drive_q <= GPC_DRIVE_RST[W-1:0]; // RULE19
        end else if (regs.wr_drive) begin
            drive_q <= regs.wdata[W-1:0] & (OD_MASK[W-1:0] | SLEW_MASK[W-1:0]); // RULE9
        end
    end

    // Output latch.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            latch_q <= GPC_LATCH_RST[W-1:0];
        end else if (regs.wr_latch) begin
            latch_q <= regs.wdata[W-1:0]; // RULE11
        end
    end

    // Pin drivers. Open drain only pulls low, so a high value releases the pin to its pull-up.
    always_comb begin
        drive_en   = dir_q | oe_term; // RULE3 RULE5 RULE6
        value      = (mode_q & addr_bits) | (~mode_q & latch_q); // RULE1 RULE11
        open_drain = drive_q & OD_MASK[W-1:0]; // RULE8
        pin_out    = value & ~open_drain;
        pin_oe_n   = ~(drive_en & ~(open_drain & value));
        slew_fast  = drive_q & SLEW_MASK[W-1:0]; // RULE9
    end

    // Readback toward the bus.
    assign regs.mode_q   = mode_q;
    assign regs.dir_q    = dir_q;
    assign regs.drive_q  = drive_q;
    assign regs.latch_q  = latch_q; // RULE12
    assign regs.oe_stat  = drive_en; // RULE16
    assign regs.pin_live = pin_in; // RULE10
endmodule : gpc_port

// [rtl/gpc_cells.sv]
// Output and input logic cells of one port, with the bus load mask.
// Assumes the logic array supplies next-state data with a load enable and an input capture strobe.
`timescale 1ns/1ps
module gpc_cells
    import gpc_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    // Register carrier.
    gpc_cell_if.cells       regs,
    // Array side.
    input  wire logic [7:0] pin_in,
    input  wire logic [7:0] cell_d,
    input  wire logic       cell_load,
    input  wire logic       icell_strobe,
    output logic      [7:0] cell_q,
    output logic      [7:0] icell_q
);
    logic [7:0] mask_q;
    logic [7:0] bus_ld;

    // Load mask.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            mask_q <= GPC_MASK_RST; // RULE14
        end else if (regs.wr_mask) begin
            mask_q <= regs.wdata;
        end
    end

    // Output cells; a bus load wins over the array on the same edge for the bits it touches.
    assign bus_ld = {8{regs.wr_cell}} & ~mask_q; // RULE13 RULE14
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cell_q <= GPC_CELL_RST;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (bus_ld[i]) begin
                    cell_q[i] <= regs.wdata[i]; // RULE13
                end else if (cell_load) begin
                    cell_q[i] <= cell_d[i];
                end
            end
        end
    end

    // Input cells capture the pins on the strobe.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            icell_q <= GPC_CELL_RST;
        end else if (icell_strobe) begin
            icell_q <= pin_in; // RULE15
        end
    end

    assign regs.cell_q  = cell_q;
    assign regs.mask_q  = mask_q;
    assign regs.icell_q = icell_q; // RULE15
endmodule : gpc_cells

// [rtl/gpc_io_config.sv]
// Top of the configurable I/O port block: bus decode, read mux, four ports and three cell banks.
// Assumes a byte bus: a window select, an 8-bit offset, one-cycle read and write strobes.
`timescale 1ns/1ps
module gpc_io_config
    import gpc_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    // Microcontroller register bus.
    input  wire logic       io_register_window_select,
    input  wire logic [7:0] bus_addr,
    input  wire logic       bus_wr,
    input  wire logic       bus_rd,
    input  wire logic [7:0] bus_wdata,
    output logic      [7:0] bus_rdata,
    // Port A pins.
    input  wire logic [7:0] pa_in,
    output logic      [7:0] pa_out,
    output logic      [7:0] pa_oe_n,
    output logic      [7:0] pa_slew_fast,
    // Port B pins.
    input  wire logic [7:0] pb_in,
    output logic      [7:0] pb_out,
    output logic      [7:0] pb_oe_n,
    output logic      [7:0] pb_slew_fast,
    // Port C pins.
    input  wire logic [7:0] pc_in,
    output logic      [7:0] pc_out,
    output logic      [7:0] pc_oe_n,
    // Port D pins.
    input  wire logic [2:0] pd_in,
    output logic      [2:0] pd_out,
    output logic      [2:0] pd_oe_n,
    output logic      [2:0] pd_slew_fast,
    // Latched address for address-out mode.
    input  wire logic [7:0] latched_addr_a,
    input  wire logic [7:0] latched_addr_b,
    // Logic-array enable terms.
    input  wire logic [7:0] array_oe_a,
    input  wire logic [7:0] array_oe_b,
    input  wire logic [7:0] array_oe_c,
    // Logic-array output cells.
    input  wire logic [7:0] cell_d_a,
    input  wire logic [7:0] cell_d_b,
    input  wire logic [7:0] cell_d_c,
    input  wire logic       cell_load_a,
    input  wire logic       cell_load_b,
    input  wire logic       cell_load_c,
    output logic      [7:0] output_logic_cell_a,
    output logic      [7:0] output_logic_cell_b,
    output logic      [7:0] output_logic_cell_c,
    // Logic-array input cells.
    input  wire logic       icell_strobe,
    output logic      [7:0] input_logic_cell_a,
    output logic      [7:0] input_logic_cell_b,
    output logic      [7:0] input_logic_cell_c
);
    logic [3:0] port_sel;
    logic [3:0] reg_sel;
    logic       wr_go;
    logic       rd_go;
    logic [7:0] rd_d;
    logic [7:0] rdata_q;

    gpc_port_if #(.W(8))            if_a ();
    gpc_port_if #(.W(8))            if_b ();
    gpc_port_if #(.W(8))            if_c ();
    gpc_port_if #(.W(GPC_PORT_D_W)) if_d ();
    gpc_cell_if                     cf_a ();
    gpc_cell_if                     cf_b ();
    gpc_cell_if                     cf_c ();

    // Offset split into port and register fields.
    assign port_sel = bus_addr[GPC_PORT_LSB +: 4];
    assign reg_sel  = bus_addr[GPC_REG_LSB +: 4];
    assign wr_go    = io_register_window_select & bus_wr; // RULE18
    assign rd_go    = io_register_window_select & bus_rd; // RULE18

    // Write strobes. Read-only offsets decode to no strobe, so a write there changes nothing.
    always_comb begin
        if_a.wdata    = bus_wdata;
        if_b.wdata    = bus_wdata;
        if_c.wdata    = bus_wdata;
        if_d.wdata    = bus_wdata;
        cf_a.wdata    = bus_wdata;
        cf_b.wdata    = bus_wdata;
        cf_c.wdata    = bus_wdata;
        if_a.wr_mode  = wr_go && port_sel == GPC_PORT_A && reg_sel == GPC_REG_MODE; // RULE2
        if_b.wr_mode  = wr_go && port_sel == GPC_PORT_B && reg_sel == GPC_REG_MODE; // RULE2
        if_c.wr_mode  = 1'b0;
        if_d.wr_mode  = 1'b0;
        if_a.wr_dir   = wr_go && port_sel == GPC_PORT_A && reg_sel == GPC_REG_DIR;
        if_b.wr_dir   = wr_go && port_sel == GPC_PORT_B && reg_sel == GPC_REG_DIR;
        if_c.wr_dir   = wr_go && port_sel == GPC_PORT_C && reg_sel == GPC_REG_DIR;
        if_d.wr_dir   = wr_go && port_sel == GPC_PORT_D && reg_sel == GPC_REG_DIR;
        if_a.wr_drive = wr_go && port_sel == GPC_PORT_A && reg_sel == GPC_REG_DRIVE;
        if_b.wr_drive = wr_go && port_sel == GPC_PORT_B && reg_sel == GPC_REG_DRIVE;
        if_c.wr_drive = wr_go && port_sel == GPC_PORT_C && reg_sel == GPC_REG_DRIVE;
        if_d.wr_drive = wr_go && port_sel == GPC_PORT_D && reg_sel == GPC_REG_DRIVE;
        if_a.wr_latch = wr_go && port_sel == GPC_PORT_A && reg_sel == GPC_REG_LATCH;
        if_b.wr_latch = wr_go && port_sel == GPC_PORT_B && reg_sel == GPC_REG_LATCH;
        if_c.wr_latch = wr_go && port_sel == GPC_PORT_C && reg_sel == GPC_REG_LATCH;
        if_d.wr_latch = wr_go && port_sel == GPC_PORT_D && reg_sel == GPC_REG_LATCH; // RULE17
        cf_a.wr_cell  = wr_go && port_sel == GPC_PORT_A && reg_sel == GPC_REG_CELL; // RULE13
        cf_b.wr_cell  = wr_go && port_sel == GPC_PORT_B && reg_sel == GPC_REG_CELL; // RULE13
        cf_c.wr_cell  = wr_go && port_sel == GPC_PORT_C && reg_sel == GPC_REG_CELL; // RULE13
        cf_a.wr_mask  = wr_go && port_sel == GPC_PORT_A && reg_sel == GPC_REG_MASK;
        cf_b.wr_mask  = wr_go && port_sel == GPC_PORT_B && reg_sel == GPC_REG_MASK;
        cf_c.wr_mask  = wr_go && port_sel == GPC_PORT_C && reg_sel == GPC_REG_MASK; // RULE20
    end

    // Port A: mode register, open drain on the high nibble, slew on the low nibble.
    gpc_port #(
        .W         (8),
        .HAS_MODE  (1'b1),
        .OD_MASK   (GPC_OD_MASK_AB),
        .SLEW_MASK (GPC_SLEW_MASK_AB)
    ) u_port_a (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .regs      (if_a),
        .pin_in    (pa_in),
        .oe_term   (array_oe_a),
        .addr_bits (latched_addr_a),
        .pin_out   (pa_out),
        .pin_oe_n  (pa_oe_n),
        .slew_fast (pa_slew_fast)
    );

    // Port B: same structure as Port A.
    gpc_port #(
        .W         (8),
        .HAS_MODE  (1'b1),
        .OD_MASK   (GPC_OD_MASK_AB),
        .SLEW_MASK (GPC_SLEW_MASK_AB)
    ) u_port_b (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .regs      (if_b),
        .pin_in    (pb_in),
        .oe_term   (array_oe_b),
        .addr_bits (latched_addr_b),
        .pin_out   (pb_out),
        .pin_oe_n  (pb_oe_n),
        .slew_fast (pb_slew_fast)
    );

    // Port C: no mode register and no address output, open drain on every bit.
    gpc_port #(
        .W         (8),
        .HAS_MODE  (1'b0),
        .OD_MASK   (GPC_OD_MASK_C),
        .SLEW_MASK (GPC_SLEW_MASK_C)
    ) u_port_c (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .regs      (if_c),
        .pin_in    (pc_in),
        .oe_term   (array_oe_c),
        .addr_bits (8'h00),
        .pin_out   (pc_out),
        .pin_oe_n  (pc_oe_n),
        .slew_fast ()
    );

    // Port D: three pins and no enable term, so direction comes from its register alone.
    gpc_port #(
        .W         (GPC_PORT_D_W),
        .HAS_MODE  (1'b0),
        .OD_MASK   (GPC_OD_MASK_D),
        .SLEW_MASK (GPC_SLEW_MASK_D)
    ) u_port_d (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .regs      (if_d),
        .pin_in    (pd_in),
        .oe_term   (3'h0), // RULE7
        .addr_bits (3'h0),
        .pin_out   (pd_out),
        .pin_oe_n  (pd_oe_n),
        .slew_fast (pd_slew_fast)
    );

    // Cell banks exist only for Ports A, B and C.
    gpc_cells u_cells_a (
        .clk_sys      (clk_sys),
        .reset_n      (reset_n),
        .regs         (cf_a),
        .pin_in       (pa_in),
        .cell_d       (cell_d_a),
        .cell_load    (cell_load_a),
        .icell_strobe (icell_strobe),
        .cell_q       (output_logic_cell_a),
        .icell_q      (input_logic_cell_a)
    );

    gpc_cells u_cells_b (
        .clk_sys      (clk_sys),
        .reset_n      (reset_n),
        .regs         (cf_b),
        .pin_in       (pb_in),
        .cell_d       (cell_d_b),
        .cell_load    (cell_load_b),
        .icell_strobe (icell_strobe),
        .cell_q       (output_logic_cell_b),
        .icell_q      (input_logic_cell_b)
    );

    gpc_cells u_cells_c (
        .clk_sys      (clk_sys),
        .reset_n      (reset_n),
        .regs         (cf_c),
        .pin_in       (pc_in),
        .cell_d       (cell_d_c),
        .cell_load    (cell_load_c),
        .icell_strobe (icell_strobe),
        .cell_q       (output_logic_cell_c),
        .icell_q      (input_logic_cell_c)
    );

    // Read mux. Anything not implemented on a port, and any unknown offset, reads as zero.
    always_comb begin
        rd_d = GPC_UNMAPPED_RD;
        unique case (port_sel)
            GPC_PORT_A: begin
                unique case (reg_sel)
                    GPC_REG_INPUT:   rd_d = if_a.pin_live; // RULE10
                    GPC_REG_LATCH:   rd_d = if_a.latch_q; // RULE12
                    GPC_REG_MODE:    rd_d = if_a.mode_q;
                    GPC_REG_DIR:     rd_d = if_a.dir_q;
                    GPC_REG_DRIVE:   rd_d = if_a.drive_q;
                    GPC_REG_OE_STAT: rd_d = if_a.oe_stat; // RULE16
                    GPC_REG_CELL:    rd_d = cf_a.cell_q; // RULE13
                    GPC_REG_MASK:    rd_d = cf_a.mask_q;
                    GPC_REG_CELL_IN: rd_d = cf_a.icell_q; // RULE15
                    default:         rd_d = GPC_UNMAPPED_RD;
                endcase
            end
            GPC_PORT_B: begin
                unique case (reg_sel)
                    GPC_REG_INPUT:   rd_d = if_b.pin_live; // RULE10
                    GPC_REG_LATCH:   rd_d = if_b.latch_q; // RULE12
                    GPC_REG_MODE:    rd_d = if_b.mode_q;
                    GPC_REG_DIR:     rd_d = if_b.dir_q;
                    GPC_REG_DRIVE:   rd_d = if_b.drive_q;
                    GPC_REG_OE_STAT: rd_d = if_b.oe_stat; // RULE16
                    GPC_REG_CELL:    rd_d = cf_b.cell_q; // RULE13
                    GPC_REG_MASK:    rd_d = cf_b.mask_q;
                    GPC_REG_CELL_IN: rd_d = cf_b.icell_q; // RULE15
                    default:         rd_d = GPC_UNMAPPED_RD;
                endcase
            end
            GPC_PORT_C: begin
                unique case (reg_sel)
                    GPC_REG_INPUT:   rd_d = if_c.pin_live; // RULE10
                    GPC_REG_LATCH:   rd_d = if_c.latch_q; // RULE12
                    GPC_REG_DIR:     rd_d = if_c.dir_q;
                    GPC_REG_DRIVE:   rd_d = if_c.drive_q;
                    GPC_REG_OE_STAT: rd_d = if_c.oe_stat; // RULE16
                    GPC_REG_CELL:    rd_d = cf_c.cell_q; // RULE13
                    GPC_REG_MASK:    rd_d = cf_c.mask_q;
                    GPC_REG_CELL_IN: rd_d = cf_c.icell_q; // RULE15
                    default:         rd_d = GPC_UNMAPPED_RD;
                endcase
            end
            GPC_PORT_D: begin
                unique case (reg_sel)
                    GPC_REG_INPUT:   rd_d = {5'h00, if_d.pin_live}; // RULE10
                    GPC_REG_LATCH:   rd_d = {5'h00, if_d.latch_q}; // RULE12
                    GPC_REG_DIR:     rd_d = {5'h00, if_d.dir_q}; // RULE7
                    GPC_REG_DRIVE:   rd_d = {5'h00, if_d.drive_q}; // RULE9
                    default:         rd_d = GPC_UNMAPPED_RD; // RULE17
                endcase
            end
            default: rd_d = GPC_UNMAPPED_RD;
        endcase
    end

    // Read data is registered on the read strobe and held until the next read.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rdata_q <= GPC_RDATA_RST;
        end else if (rd_go) begin
            rdata_q <= rd_d; // RULE18
        end
    end

    assign bus_rdata = rdata_q;
endmodule : gpc_io_config

// [sim/gpc_monitor.sv]
// Checker on the I/O port top ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module gpc_monitor (
    input wire logic       clk_sys, reset_n, io_register_window_select, bus_wr, bus_rd, cell_load_a, icell_strobe,
    input wire logic [7:0] bus_addr, bus_rdata, pa_in, pa_oe_n, pa_slew_fast, pb_oe_n, pb_slew_fast,
    input wire logic [7:0] array_oe_a, array_oe_b, latched_addr_a, cell_d_a, output_logic_cell_a,
    input wire logic [7:0] input_logic_cell_a
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Taken bus cycles; their effects show one cycle later.
    sequence s_wr(a); bus_wr && io_register_window_select && bus_addr == a; endsequence
    sequence s_rd(a); bus_rd && io_register_window_select && bus_addr == a; endsequence
    a_pin_read: assert property (s_rd(8'h00) |=> bus_rdata == $past(pa_in))
        else $error("pin read");
    a_read_hold: assert property (!(bus_rd && io_register_window_select) |=> $stable(bus_rdata))
        else $error("read data moved");
    a_term_drives: assert property ((pb_oe_n[3:0] & array_oe_b[3:0]) == 4'h0)
        else $error("enable term ignored");
    a_slew_unused: assert property (pa_slew_fast[7:4] == 4'h0 && pb_slew_fast[7:4] == 4'h0)
        else $error("slew on open drain bits");
    a_reset_idle: assert property ($rose(reset_n) && array_oe_a == 8'h00 |-> pa_oe_n == 8'hFF)
        else $error("pins not inputs");
    a_cell_load: assert property (cell_load_a && !(bus_wr && io_register_window_select && bus_addr == 8'h06)
        |=> output_logic_cell_a == $past(cell_d_a)) else $error("cell load");
    a_icell_capture: assert property (icell_strobe |=> input_logic_cell_a == $past(pa_in))
        else $error("input cell");
    a_ro_write: assert property (s_wr(8'h05) |=> $stable(array_oe_a) && $stable(latched_addr_a)
        |-> $stable(pa_oe_n)) else $error("read-only write");
endmodule : gpc_monitor
bind gpc_io_config gpc_monitor i_gpc_monitor (.clk_sys, .reset_n, .io_register_window_select, .bus_wr,
    .bus_rd, .cell_load_a, .icell_strobe, .bus_addr, .bus_rdata, .pa_in, .pa_oe_n, .pa_slew_fast, .pb_oe_n,
    .pb_slew_fast, .array_oe_a, .array_oe_b, .latched_addr_a, .cell_d_a, .output_logic_cell_a,
    .input_logic_cell_a);

// [sim/gpc_pin_model.sv]
// Far-side pad model of one port.
// Assumes oe_n low while the block drives; a released pad takes the outside level.
`timescale 1ns/1ps
module gpc_pin_model (
    input  wire logic [7:0] pin_out, pin_oe_n, ext_drive,
    output logic      [7:0] pad
);
    // Released pads, open drain ones too, follow the outside source.
    assign pad = (pin_out & ~pin_oe_n) | (ext_drive & pin_oe_n);
endmodule : gpc_pin_model

// [sim/tb_top.sv]
// Testbench for the I/O port top: bus tasks, scenarios, verdict.
// Assumes the package register layout and one-cycle read latency.
`timescale 1ns/1ps
module tb_top;
    logic       clk_sys = 1'b0, reset_n = 1'b0, sel = 1'b0, bwr = 1'b0, brd = 1'b0, cload = 1'b0, istb = 1'b0;
    logic [7:0] addr = 8'h00, wd = 8'h00, pin = 8'h00, lg = 8'h00, aoa = 8'h00, extc = 8'h00;
    logic [7:0] rdat, pa_out, pa_oe_n, pa_slew, pc_out, pc_oe_n, pc_pad, ocb;
    logic [2:0] pd_out, pd_oe_n, pd_slew;
    int         errors = 0, cmp_count = 0;
    always #4 clk_sys = ~clk_sys;
    gpc_io_config i_gpc_io_config (.clk_sys, .reset_n, .io_register_window_select(sel), .bus_addr(addr),
        .bus_wr(bwr), .bus_rd(brd), .bus_wdata(wd), .bus_rdata(rdat), .pa_in(pin), .pa_out, .pa_oe_n,
        .pa_slew_fast(pa_slew), .pb_in(pin), .pb_out(), .pb_oe_n(), .pb_slew_fast(), .pc_in(pc_pad), .pc_out,
        .pc_oe_n, .pd_in(pin[2:0]), .pd_out, .pd_oe_n, .pd_slew_fast(pd_slew), .latched_addr_a(lg),
        .latched_addr_b(lg), .array_oe_a(aoa), .array_oe_b(aoa), .array_oe_c(8'h00), .cell_d_a(lg),
        .cell_d_b(lg), .cell_d_c(lg), .cell_load_a(cload), .cell_load_b(cload), .cell_load_c(cload),
        .output_logic_cell_a(), .output_logic_cell_b(ocb), .output_logic_cell_c(), .icell_strobe(istb),
        .input_logic_cell_a(), .input_logic_cell_b(), .input_logic_cell_c());
    gpc_pin_model i_gpc_pin_model (.pin_out(pc_out), .pin_oe_n(pc_oe_n), .ext_drive(extc), .pad(pc_pad));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Each access takes two edges so no strobe is set twice at one edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sel <= 1'b1; addr <= a; wd <= d; bwr <= 1'b1;
        @(posedge clk_sys); bwr <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        sel <= 1'b1; addr <= a; brd <= 1'b1;
        @(posedge clk_sys); brd <= 1'b0;
        @(posedge clk_sys); chk($sformatf("reg %h", a), e, rdat);
    endtask : rd
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test
    // Guard against a hang.
    initial begin
        repeat (5000) @(posedge clk_sys);
        errors++;
        end_of_test;
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        for (int i = 0; i < 9; i++) rd(8'(i), 8'h00);
        chk("pa_oe_n", 8'hFF, pa_oe_n);
        $display("test reset done");
        wr(8'h03, 8'h07); wr(8'h33, 8'hFF); aoa <= 8'h33;
        rd(8'h33, 8'h07); chk("pd_oe_n", 8'h00, {5'h0, pd_oe_n});
        rd(8'h05, 8'h37); chk("pa_oe_n", 8'hC8, pa_oe_n);
        wr(8'h01, 8'hA5); rd(8'h01, 8'hA5); chk("pa_out", 8'h25, pa_out & 8'h37);
        lg <= 8'h3C; wr(8'h02, 8'hFF); chk("pa_out", 8'h34, pa_out & 8'h37);
        wr(8'h02, 8'h00); wr(8'h04, 8'hFF); chk("pa_oe_n", 8'hE8, pa_oe_n);
        rd(8'h05, 8'h37); chk("pa_slew", 8'h0F, pa_slew);
        wr(8'h34, 8'hFF); rd(8'h34, 8'h07); chk("pd_slew", 8'h07, {5'h0, pd_slew});
        wr(8'h31, 8'h05); chk("pd_out", 8'h05, {5'h0, pd_out});
        $display("test config done");
        wr(8'h17, 8'hF0); wr(8'h16, 8'hFF); rd(8'h16, 8'h0F);
        cload <= 1'b1; @(posedge clk_sys); cload <= 1'b0; @(posedge clk_sys);
        chk("cell_b", 8'h3C, ocb);
        extc <= 8'h5A; pin <= 8'h96; istb <= 1'b1; @(posedge clk_sys); istb <= 1'b0;
        rd(8'h20, 8'h5A); rd(8'h28, 8'h5A); rd(8'h00, 8'h96);
        wr(8'h23, 8'hFF); wr(8'h21, 8'h0F); rd(8'h20, 8'h0F);
        wr(8'h05, 8'h00); wr(8'h00, 8'hFF); wr(8'h22, 8'hFF); wr(8'h28, 8'hFF); wr(8'h37, 8'hFF);
        rd(8'h05, 8'h37); rd(8'h22, 8'h00); rd(8'h28, 8'h5A); rd(8'h37, 8'h00);
        rd(8'h4F, 8'h00);
        $display("test data done");
        end_of_test;
    end
endmodule : tb_top
